// ===== ddr2_mem_end.sv
`timescale 1ns/10ps
`include "ddr2_lp_defs.svh"
module ddr2_mem_end
   import ddr2_lp_pkg::*;
(
   input wire logic clk, // command clock
   input wire logic rstn, // async reset, active low
   ddr2_cmd_if.mem bus, // command bus from controller
   input wire logic fastExit, // active power-down keeps dll running
   output logic [7:0] bankOpen, // per-bank row open
   output logic [7:0] bankPrecharging, // per-bank precharge underway
   output logic [3:0] pwrState, // one-hot power state
   output logic dllOn, // dll enabled
   output logic inBufOn, // command input buffers enabled
   output logic [12:0] refRow // internal refresh row counter
);
   pwr_t pwr_ff, nxt_pwr;
   logic ckePrev_ff, nxt_ckePrev;
   logic [12:0] refRow_ff, nxt_refRow;
   logic [7:0] refBusy_ff, nxt_refBusy;
   logic [7:0] open_ff, nxt_open;
   logic [7:0] apArm_ff, nxt_apArm; // auto precharge pending per bank
   logic [7:0] pchg_ff, nxt_pchg;
   logic [7:0] apWait_ff [`NBANK]; // cycles until auto precharge may start
   logic [7:0] nxt_apWait [`NBANK];
   logic [7:0] rasAge_ff [`NBANK]; // cycles since activation, saturating
   logic [7:0] nxt_rasAge [`NBANK];
   logic [7:0] pchgCnt_ff [`NBANK];
   logic [7:0] nxt_pchgCnt [`NBANK];
   cmd_t cmd;
   logic awake;

   // commands count only while awake and CKE stayed high
   always_comb begin
      cmd = decode_cmd(bus.csN, bus.rasN, bus.casN, bus.weN);
      awake = (pwr_ff == PWR_AWAKE) && ckePrev_ff && bus.cke;
   end

   // power state: self-refresh, power-down entry and exit
   always_comb begin
      nxt_pwr = pwr_ff;
      nxt_ckePrev = bus.cke;
      unique case (pwr_ff)
         PWR_AWAKE: begin
            if (ckePrev_ff && !bus.cke) begin
               if (cmd == CMD_REF) begin
                  nxt_pwr = PWR_SELFREF;
               end else if (cmd == CMD_NOP || cmd == CMD_DESEL) begin
                  // idle banks give precharge power-down
                  nxt_pwr = (|open_ff) ? PWR_ACTPD : PWR_PREPD;
               end
            end
         end
         PWR_PREPD, PWR_ACTPD: begin
            // exit on CKE high with nop or deselect
            if (bus.cke && (cmd == CMD_NOP || cmd == CMD_DESEL)) begin
               nxt_pwr = PWR_AWAKE;
            end
         end
         PWR_SELFREF: begin
            // only CKE is watched here
            if (bus.cke) begin
               nxt_pwr = PWR_AWAKE;
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pwr_ff <= PWR_AWAKE;
         ckePrev_ff <= 1'b0;
      end else begin
         pwr_ff <= nxt_pwr;
         ckePrev_ff <= nxt_ckePrev;
      end
   end

   // refresh row counter and per-bank refresh busy marking
   always_comb begin
      nxt_refRow = refRow_ff;
      nxt_refBusy = '0;
      if (awake && cmd == CMD_REF) begin
         // address bus ignored, row from counter
         nxt_refRow = refRow_ff + 13'h0001;
         nxt_refBusy = 8'hFF;
      end
      if (pwr_ff == PWR_SELFREF) begin
         nxt_refRow = refRow_ff + 13'h0001; // internal timer walks rows
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         refRow_ff <= 13'h0000;
         refBusy_ff <= 8'h00;
      end else begin
         refRow_ff <= nxt_refRow;
         refBusy_ff <= nxt_refBusy;
      end
   end

   // per-bank row state with auto precharge scheduling
   always_comb begin
      nxt_open = open_ff;
      nxt_apArm = apArm_ff;
      nxt_pchg = pchg_ff;
      for (int b = 0; b < `NBANK; b++) begin
         nxt_apWait[b] = (apWait_ff[b] != 8'h00) ? apWait_ff[b] - 8'h01 : 8'h00;
         nxt_rasAge[b] = (rasAge_ff[b] != 8'hFF) ? rasAge_ff[b] + 8'h01 : 8'hFF;
         nxt_pchgCnt[b] = (pchgCnt_ff[b] != 8'h00) ? pchgCnt_ff[b] - 8'h01 : 8'h00;
         if (pchg_ff[b] && pchgCnt_ff[b] == 8'h01) begin
            nxt_pchg[b] = 1'b0;
         end
         // start precharge once the wait ran out and the row is restored
         // age reads zero on the edge after the activate, hence one less than tRAS
         if (apArm_ff[b] && apWait_ff[b] == 8'h00 && rasAge_ff[b] >= `TRAS_CYC - 8'h01) begin
            nxt_apArm[b] = 1'b0;
            nxt_open[b] = 1'b0;
            nxt_pchg[b] = 1'b1;
            nxt_pchgCnt[b] = `TRP_CYC;
         end
         if (awake && bus.ba == 3'(b)) begin
            unique case (cmd)
               CMD_ACT: begin
                  nxt_open[b] = 1'b1;
                  nxt_rasAge[b] = 8'h00;
               end
               CMD_READ: begin
                  if (bus.addr[`AUTOPRE_BIT]) begin
                     nxt_apArm[b] = 1'b1;
                     nxt_apWait[b] = 8'(`AL_CYC + `BL_HALF - 4'h1);
                  end
               end
               CMD_WRITE: begin
                  if (bus.addr[`AUTOPRE_BIT]) begin
                     // last data stored, then write recovery
                     nxt_apArm[b] = 1'b1;
                     nxt_apWait[b] = 8'(`WL_CYC + `BL_HALF) + `TWR_CYC - 8'h01;
                  end
               end
               CMD_PRE: begin
                  nxt_open[b] = 1'b0;
                  nxt_pchg[b] = 1'b1;
                  nxt_pchgCnt[b] = `TRP_CYC;
               end
               default: begin
               end
            endcase
         end
         if (awake && cmd == CMD_PRE && bus.addr[`AUTOPRE_BIT]) begin
            nxt_open[b] = 1'b0;
         end
         if (refBusy_ff[b]) begin
            nxt_open[b] = 1'b0;
            nxt_apArm[b] = 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         open_ff <= 8'h00;
         apArm_ff <= 8'h00;
         pchg_ff <= 8'h00;
         for (int b = 0; b < `NBANK; b++) begin
            apWait_ff[b] <= 8'h00;
            rasAge_ff[b] <= 8'hFF;
            pchgCnt_ff[b] <= 8'h00;
         end
      end else begin
         open_ff <= nxt_open;
         apArm_ff <= nxt_apArm;
         pchg_ff <= nxt_pchg;
         for (int b = 0; b < `NBANK; b++) begin
            apWait_ff[b] <= nxt_apWait[b];
            rasAge_ff[b] <= nxt_rasAge[b];
            pchgCnt_ff[b] <= nxt_pchgCnt[b];
         end
      end
   end

   // status outputs, all registered
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         bankOpen <= 8'h00;
         bankPrecharging <= 8'h00;
         pwrState <= 4'b0001;
         dllOn <= 1'b1;
         inBufOn <= 1'b1;
         refRow <= 13'h0000;
      end else begin
         bankOpen <= nxt_open;
         bankPrecharging <= nxt_pchg;
         pwrState <= nxt_pwr;
         // dll stays on only in fast-exit active power-down
         dllOn <= (nxt_pwr == PWR_AWAKE) || (nxt_pwr == PWR_ACTPD && fastExit);
         inBufOn <= (nxt_pwr == PWR_AWAKE);
         refRow <= nxt_refRow;
      end
   end
endmodule

// ===== ddr2_lp_defs.svh
`ifndef DDR2_LP_DEFS_SVH
`define DDR2_LP_DEFS_SVH
// timing counts in clock cycles of the 250 MHz command clock
`define NBANK 8
`define AL_CYC 4'h2
`define BL_HALF 4'h2
`define WL_CYC 4'h4
`define TRAS_CYC 8'h0B
`define TRP_CYC 8'h04
`define TRC_CYC 8'h0F
`define TWR_CYC 8'h04
`define TRFC_CYC 8'h20
`define TXSNR_CYC 8'h24
`define TXSRD_CYC 8'hC8
`define TXP_CYC 8'h02
`define TXARDS_CYC 8'h07
`define TCKE_CYC 8'h03
`define TAOFD_CYC 8'h03
// refresh window figures: 64 ms over 8192 rows gives 7.8 us
`define TREFI_NS 7800
`define CLK_NS 4
`define TREFI_CYC (`TREFI_NS / `CLK_NS)
`define MAX_POSTED 8
`define MAX_GAP_REFI 9
// A10 position on the address bus
`define AUTOPRE_BIT 10
`endif

// ===== ddr2_lp_pkg.sv
package ddr2_lp_pkg;
   typedef enum logic [3:0] {
      CMD_NOP = 4'h0,
      CMD_DESEL = 4'h1,
      CMD_ACT = 4'h2,
      CMD_READ = 4'h3,
      CMD_WRITE = 4'h4,
      CMD_PRE = 4'h5,
      CMD_REF = 4'h6,
      CMD_SELF = 4'h7,
      CMD_OTHER = 4'h8
   } cmd_t;
   typedef enum logic [3:0] {
      REQ_NONE = 4'h0,
      REQ_ACT = 4'h1,
      REQ_READ = 4'h2,
      REQ_WRITE = 4'h3,
      REQ_PRE = 4'h4,
      REQ_REF = 4'h5,
      REQ_SELF = 4'h6,
      REQ_SLEEP = 4'h7,
      REQ_WAKE = 4'h8
   } req_t;
   typedef enum logic [3:0] {
      PWR_AWAKE = 4'b0001,
      PWR_PREPD = 4'b0010,
      PWR_ACTPD = 4'b0100,
      PWR_SELFREF = 4'b1000
   } pwr_t;
   // decode of the four command strobes (all active low)
   function automatic cmd_t decode_cmd(input logic csN, input logic rasN, input logic casN, input logic weN);
      if (csN) return CMD_DESEL;
      unique case ({rasN, casN, weN})
         3'b111: return CMD_NOP;
         3'b011: return CMD_ACT;
         3'b101: return CMD_READ;
         3'b100: return CMD_WRITE;
         3'b010: return CMD_PRE;
         3'b001: return CMD_REF;
         default: return CMD_OTHER;
      endcase
   endfunction
endpackage

// ===== ddr2_cmd_if.sv
`timescale 1ns/10ps
interface ddr2_cmd_if;
   logic cke;
   logic csN;
   logic rasN;
   logic casN;
   logic weN;
   logic [13:0] addr;
   logic [2:0] ba;
   logic odt;
   modport ctrl (output cke, csN, rasN, casN, weN, addr, ba, odt);
   modport mem (input cke, csN, rasN, casN, weN, addr, ba, odt);
endinterface

// ===== ddr2_ctrl_end.sv
`timescale 1ns/10ps
`include "ddr2_lp_defs.svh"
module ddr2_ctrl_end
   import ddr2_lp_pkg::*;
(
   input wire logic clk, // command clock
   input wire logic rstn, // async reset, active low
   ddr2_cmd_if.ctrl bus, // command bus to memory
   input req_t req, // user request, held until accepted
   input wire logic [2:0] reqBank, // bank of request
   input wire logic [13:0] reqAddr, // row or column, bit 10 = auto precharge
   output logic reqAck, // one-cycle pulse: request issued
   output logic refUrgent // refresh debt reached the limit
);
   logic cke_ff, csN_ff, rasN_ff, casN_ff, weN_ff, odt_ff;
   logic [13:0] addr_ff;
   logic [2:0] ba_ff;
   logic [7:0] open_ff;
   logic [7:0] actAge_ff [`NBANK]; // cycles since activation
   logic [7:0] idleAge_ff [`NBANK]; // cycles since precharge began
   logic [7:0] apWait_ff [`NBANK]; // cycles until auto precharge begins
   logic [7:0] gap_ff; // general command holdoff (tRFC, exits, tCKE, read/write bursts)
   logic inSelf_ff, inPd_ff;
   logic [15:0] refiCnt_ff;
   logic [3:0] owed_ff;
   logic ok;
   logic allIdle;

   // legality check against per-bank timers
   always_comb begin
      allIdle = 1'b1;
      for (int b = 0; b < `NBANK; b++) begin
         if (open_ff[b] || apWait_ff[b] != 8'h00 || idleAge_ff[b] < `TRP_CYC) allIdle = 1'b0;
      end
      // the requester still holds req on the edge that sees the ack, so that edge must not take it again
      ok = (gap_ff == 8'h00) && !reqAck;
      unique case (req)
         REQ_ACT: ok = ok && !inSelf_ff && !inPd_ff && !open_ff[reqBank] && apWait_ff[reqBank] == 8'h00
            && idleAge_ff[reqBank] >= `TRP_CYC && actAge_ff[reqBank] >= `TRC_CYC;
         REQ_READ, REQ_WRITE: ok = ok && !inSelf_ff && !inPd_ff && open_ff[reqBank];
         REQ_PRE: ok = ok && !inSelf_ff && !inPd_ff && actAge_ff[reqBank] >= `TRAS_CYC;
         REQ_REF, REQ_SELF: ok = ok && !inSelf_ff && !inPd_ff && allIdle && !odt_ff;
         REQ_SLEEP: ok = ok && !inSelf_ff && !inPd_ff;
         REQ_WAKE: ok = ok && (inSelf_ff || inPd_ff);
         default: ok = 1'b0;
      endcase
   end

   // command drive, bank tracking and refresh accounting
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cke_ff <= 1'b1;
         {csN_ff, rasN_ff, casN_ff, weN_ff} <= 4'hF;
         odt_ff <= 1'b0;
         addr_ff <= 14'h0000;
         ba_ff <= 3'h0;
         open_ff <= 8'h00;
         gap_ff <= 8'h00;
         inSelf_ff <= 1'b0;
         inPd_ff <= 1'b0;
         refiCnt_ff <= 16'h0000;
         owed_ff <= 4'h0;
         reqAck <= 1'b0;
         refUrgent <= 1'b0;
         for (int b = 0; b < `NBANK; b++) begin
            actAge_ff[b] <= 8'hFF;
            idleAge_ff[b] <= 8'hFF;
            apWait_ff[b] <= 8'h00;
         end
      end else begin
         {csN_ff, rasN_ff, casN_ff, weN_ff} <= 4'h7; // nop by default
         reqAck <= ok;
         gap_ff <= (gap_ff != 8'h00) ? gap_ff - 8'h01 : 8'h00;
         for (int b = 0; b < `NBANK; b++) begin
            if (actAge_ff[b] != 8'hFF) actAge_ff[b] <= actAge_ff[b] + 8'h01;
            if (idleAge_ff[b] != 8'hFF && !open_ff[b]) idleAge_ff[b] <= idleAge_ff[b] + 8'h01;
            if (apWait_ff[b] == 8'h01) idleAge_ff[b] <= 8'h00;
            if (apWait_ff[b] != 8'h00) apWait_ff[b] <= apWait_ff[b] - 8'h01;
         end
         // refresh debt: one owed per interval except in self-refresh, limit 8 posted
         if (refiCnt_ff == 16'(`TREFI_CYC - 1)) begin
            refiCnt_ff <= 16'h0000;
            if (!inSelf_ff && owed_ff != 4'hF) owed_ff <= owed_ff + 4'h1;
         end else begin
            refiCnt_ff <= refiCnt_ff + 16'h0001;
         end
         refUrgent <= (owed_ff >= 4'(`MAX_POSTED));
         if (ok) begin
            addr_ff <= reqAddr;
            ba_ff <= reqBank;
            unique case (req)
               REQ_ACT: begin
                  {csN_ff, rasN_ff, casN_ff, weN_ff} <= 4'h3;
                  open_ff[reqBank] <= 1'b1;
                  actAge_ff[reqBank] <= 8'h00;
               end
               REQ_READ, REQ_WRITE: begin
                  {csN_ff, rasN_ff, casN_ff, weN_ff} <= (req == REQ_READ) ? 4'h5 : 4'h4;
                  if (reqAddr[`AUTOPRE_BIT]) begin
                     open_ff[reqBank] <= 1'b0;
                     apWait_ff[reqBank] <= (req == REQ_READ) ? 8'(`AL_CYC + `BL_HALF)
                        : 8'(`WL_CYC + `BL_HALF) + `TWR_CYC;
                  end
                  gap_ff <= 8'(`BL_HALF); // no cke drop mid burst
               end
               REQ_PRE: begin
                  {csN_ff, rasN_ff, casN_ff, weN_ff} <= 4'h2;
                  open_ff[reqBank] <= 1'b0;
                  idleAge_ff[reqBank] <= 8'h00;
               end
               REQ_REF: begin
                  {csN_ff, rasN_ff, casN_ff, weN_ff} <= 4'h1;
                  gap_ff <= `TRFC_CYC;
                  if (owed_ff != 4'h0) owed_ff <= owed_ff - 4'h1;
               end
               REQ_SELF: begin
                  {csN_ff, rasN_ff, casN_ff, weN_ff} <= 4'h1;
                  cke_ff <= 1'b0;
                  inSelf_ff <= 1'b1;
                  gap_ff <= `TCKE_CYC;
               end
               REQ_SLEEP: begin
                  cke_ff <= 1'b0;
                  inPd_ff <= 1'b1;
                  gap_ff <= `TCKE_CYC;
               end
               default: begin
                  // wake: cke high with nop, then exit latency
                  cke_ff <= 1'b1;
                  inSelf_ff <= 1'b0;
                  inPd_ff <= 1'b0;
                  gap_ff <= inSelf_ff ? `TXSRD_CYC : (|open_ff ? `TXARDS_CYC : `TXP_CYC);
                  if (inSelf_ff) owed_ff <= 4'h0;
               end
            endcase
         end
      end
   end

   // interface drive, each from a flip-flop; odt held low (off) throughout
   always_comb begin
      bus.cke = cke_ff;
      bus.csN = csN_ff;
      bus.rasN = rasN_ff;
      bus.casN = casN_ff;
      bus.weN = weN_ff;
      bus.addr = addr_ff;
      bus.ba = ba_ff;
      bus.odt = odt_ff;
   end
endmodule

// ===== ddr2_lp_chk.sv
`timescale 1ns/10ps
`include "ddr2_lp_defs.svh"
module ddr2_lp_chk (
   input wire logic clk, // command clock
   input wire logic rstn, // async reset, active low
   input wire logic cke, // clock enable
   input wire logic csN, // chip select, active low
   input wire logic rasN, // row strobe, active low
   input wire logic casN, // column strobe, active low
   input wire logic weN, // write enable, active low
   input wire logic [13:0] addr, // address bus
   input wire logic [2:0] ba, // bank address
   input wire logic odt // termination control
);
   logic isNop, isRef, isAct, isCmd, selfOn_ff, nxt_selfOn;
   logic [7:0] refCnt_ff, nxt_refCnt, exitCnt_ff, nxt_exitCnt;
   logic [7:0] actCnt_ff [8];
   logic [7:0] nxt_actCnt [8];
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // own strobe decode, so a slip in the shared decode is not copied here
   assign isNop = csN | (rasN & casN & weN);
   assign isRef = !csN & !rasN & !casN & weN;
   assign isAct = !csN & !rasN & casN & weN;
   assign isCmd = cke & !isNop;
   // saturating ages since refresh, self-refresh exit and each activate
   always_comb begin
      nxt_refCnt = (isRef & cke) ? 8'h01 : refCnt_ff + {7'h00, refCnt_ff != 8'hFF};
      nxt_selfOn = (isRef & !cke) | (selfOn_ff & !cke);
      nxt_exitCnt = (selfOn_ff & cke) ? 8'h01 : exitCnt_ff + {7'h00, exitCnt_ff != 8'hFF};
      for (int b = 0; b < 8; b++) begin
         nxt_actCnt[b] = (isAct & cke & (ba == 3'(b))) ? 8'h01 : actCnt_ff[b] + {7'h00, actCnt_ff[b] != 8'hFF};
      end
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         refCnt_ff <= 8'hFF;
         exitCnt_ff <= 8'hFF;
         selfOn_ff <= 1'b0;
         for (int b = 0; b < 8; b++) actCnt_ff[b] <= 8'hFF;
      end else begin
         refCnt_ff <= nxt_refCnt;
         exitCnt_ff <= nxt_exitCnt;
         selfOn_ff <= nxt_selfOn;
         for (int b = 0; b < 8; b++) actCnt_ff[b] <= nxt_actCnt[b];
      end
   end
   a_odt_kept_off: assert property (odt == 1'b0) else $error("termination driven on");
   a_ref_to_next: assert property (cke && (isRef || isAct) |-> refCnt_ff >= `TRFC_CYC)
      else $error("refresh spacing too short");
   a_act_row_cycle: assert property (cke && isAct |-> actCnt_ff[ba] >= `TRC_CYC)
      else $error("activate too soon on bank");
   a_cke_low_hold: assert property ($fell(cke) |-> !cke [*3]) else $error("cke low too short");
   a_cke_high_hold: assert property ($rose(cke) |-> cke [*3]) else $error("cke high too short");
   a_sleep_with_nop: assert property ($fell(cke) |-> isNop || isRef) else $error("cke fell with command");
   a_wake_with_nop: assert property ($rose(cke) |-> isNop ##1 isNop) else $error("command before exit latency");
   a_self_exit_quiet: assert property (exitCnt_ff < `TXSRD_CYC |-> cke && isNop)
      else $error("command inside self-refresh exit");
   a_cmd_one_cycle: assert property (isCmd |=> isNop) else $error("command held over one cycle");
   cover property (isRef && cke);
   cover property (isRef && !cke);
   cover property ($rose(cke));
   cover property (isAct && cke);
endmodule

// ===== ddr2_autoprecharge_refresh_powerdown_tb.sv
`timescale 1ns/10ps
`include "ddr2_lp_defs.svh"
module ddr2_autoprecharge_refresh_powerdown_tb
   import ddr2_lp_pkg::*;
;
   logic clk, rstn, fastExit, reqAck, refUrgent, dllOn, inBufOn, colA10;
   req_t req;
   logic [2:0] reqBank;
   logic [13:0] reqAddr;
   logic [7:0] bankOpen, bankPrecharging;
   logic [3:0] pwrState;
   logic [12:0] refRow, r0;
   int cyc = 0;
   int colAt = 0;
   int actAt [8];
   int miscompares = 0;
   int testsRun = 0;
   ddr2_cmd_if cmdBus();
   ddr2_ctrl_end ddr2_ctrl_end_i (.clk(clk), .rstn(rstn), .bus(cmdBus), .req(req), .reqBank(reqBank),
      .reqAddr(reqAddr), .reqAck(reqAck), .refUrgent(refUrgent));
   ddr2_mem_end ddr2_mem_end_i (.clk(clk), .rstn(rstn), .bus(cmdBus), .fastExit(fastExit), .bankOpen(bankOpen),
      .bankPrecharging(bankPrecharging), .pwrState(pwrState), .dllOn(dllOn), .inBufOn(inBufOn), .refRow(refRow));
   ddr2_lp_chk ddr2_lp_chk_i (.clk(clk), .rstn(rstn), .cke(cmdBus.cke), .csN(cmdBus.csN), .rasN(cmdBus.rasN),
      .casN(cmdBus.casN), .weN(cmdBus.weN), .addr(cmdBus.addr), .ba(cmdBus.ba), .odt(cmdBus.odt));
   always #2 clk = ~clk;
   // bus monitor: edge numbers of the commands the memory end samples
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cmdBus.cke && !cmdBus.csN && !cmdBus.rasN && cmdBus.casN && cmdBus.weN) actAt[cmdBus.ba] <= cyc;
      if (cmdBus.cke && !cmdBus.csN && cmdBus.rasN && !cmdBus.casN) begin
         colAt <= cyc;
         colA10 <= cmdBus.addr[10];
      end
   end
   // a hang is cut short well past the longest expected run
   always @(posedge clk) begin
      if (cyc == 30000) begin
         miscompares++;
         final_report;
      end
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      testsRun++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic waitTo(input int c);
      while (cyc < c) @(posedge clk);
   endtask
   // request is held until the acknowledge is seen at an edge
   task automatic issue(input req_t r, input logic [2:0] b, input logic [13:0] a);
      int n;
      n = 0;
      req <= r;
      reqBank <= b;
      reqAddr <= a;
      @(posedge clk);
      while (reqAck !== 1'b1 && n < 3000) begin
         @(posedge clk);
         n++;
      end
      req <= REQ_NONE;
      chk(reqAck, 1'b1);
      // one idle edge so a following call never reassigns req in the same step
      @(posedge clk);
   endtask
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", testsRun, miscompares);
      if (miscompares == 0 && testsRun > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      int b, s;
      logic ap;
      clk = 1'b0;
      rstn = 1'b0;
      fastExit = 1'b0;
      req = REQ_NONE;
      reqBank = 3'h0;
      reqAddr = 14'h0000;
      void'($urandom(63));
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      // refresh debt builds from reset release and one refresh pays it down
      waitTo(7 * `TREFI_CYC);
      chk(refUrgent, 1'b0);
      waitTo(8 * `TREFI_CYC + 20);
      chk(refUrgent, 1'b1);
      r0 = refRow;
      issue(REQ_REF, 3'h0, 14'h3FFF);
      idle(3);
      chk(refUrgent, 1'b0);
      chk(refRow, 13'(r0 + 1));
      chk(bankOpen, 8'h00);
      // read then write, each plain and with auto precharge, all on one bank
      b = $urandom % 8;
      s = 0;
      for (int k = 0; k < 5; k++) begin
         ap = k[0];
         issue(REQ_ACT, 3'(b), 14'($urandom));
         idle(2);
         chk(bankOpen[b], 1'b1);
         if (k == 2 || k == 4) chk(actAt[b] >= s + `TRP_CYC, 1'b1);
         if (k == 4) break;
         issue(k[1] ? REQ_WRITE : REQ_READ, 3'(b), {3'h0, ap, 10'($urandom)});
         idle(1);
         chk(colA10, ap);
         if (ap) begin
            s = colAt + (k[1] ? `WL_CYC + `BL_HALF + `TWR_CYC : `AL_CYC + `BL_HALF);
            if (s < actAt[b] + `TRAS_CYC) s = actAt[b] + `TRAS_CYC;
            waitTo(s);
            chk(bankPrecharging[b], 1'b0);
            waitTo(s + 1);
            chk(bankPrecharging[b], 1'b1);
            waitTo(s + `TRP_CYC + 1);
            chk({bankOpen[b], bankPrecharging[b]}, 2'b00);
         end else begin
            idle(20);
            chk(bankOpen[b], 1'b1);
            issue(REQ_PRE, 3'(b), 14'h0000);
            idle(`TRP_CYC + 2);
            chk(bankOpen[b], 1'b0);
         end
      end
      // active power-down slow and fast exit, then precharge power-down
      for (int m = 0; m < 3; m++) begin
         fastExit <= (m == 1);
         if (m == 2) begin
            issue(REQ_PRE, 3'(b), 14'h0000);
            idle(`TRP_CYC + 2);
         end
         issue(REQ_SLEEP, 3'h0, 14'h0000);
         idle(3);
         chk(pwrState, (m == 2) ? 4'h2 : 4'h4);
         chk(dllOn, m == 1);
         chk(inBufOn, 1'b0);
         idle(10);
         issue(REQ_WAKE, 3'h0, 14'h0000);
         idle(4);
         chk({pwrState, inBufOn}, 5'h03);
      end
      // self-refresh: internal timer runs, cke held low, long exit
      issue(REQ_SELF, 3'h0, 14'h0000);
      idle(3);
      chk(pwrState, 4'h8);
      r0 = refRow;
      idle(10);
      chk(refRow != r0, 1'b1);
      chk(cmdBus.cke, 1'b0);
      issue(REQ_WAKE, 3'h0, 14'h0000);
      idle(4);
      chk(pwrState, 4'h1);
      issue(REQ_ACT, 3'(b), 14'($urandom));
      idle(2);
      chk(bankOpen[b], 1'b1);
      final_report;
   end
endmodule
